//--- common/video_dac_pkg.sv
// shared constants for the video converter input port
package video_dac_pkg;
	localparam int CODE_WIDTH = 10;
	localparam int LEVEL_COUNT = 1024;
	localparam logic [9:0] CODE_BLACK = 10'h000;
	localparam logic [9:0] CODE_WHITE = 10'h3FF;
	localparam logic [9:0] CODE_RESET = 10'h000;
	// power-up times, ns
	localparam int STANDBY_UP_NS = 10;
	localparam int POWER_OFF_UP_NS = 320;
	localparam int CLK_PERIOD_NS = 8;
	// longest times round down, at least one cycle
	localparam int STANDBY_UP_CYCLES =
		(STANDBY_UP_NS / CLK_PERIOD_NS) < 1 ? 1 : (STANDBY_UP_NS / CLK_PERIOD_NS);
	localparam int POWER_OFF_UP_CYCLES =
		(POWER_OFF_UP_NS / CLK_PERIOD_NS) < 1 ? 1 : (POWER_OFF_UP_NS / CLK_PERIOD_NS);
	localparam int WAKE_WIDTH = 6;
	typedef enum logic [1:0] {
		ST_OFF,
		ST_STANDBY,
		ST_WAKE,
		ST_RUN
	} power_state_t;
endpackage

//--- rtl/video_dac_input_port.sv
// pixel input register and power control for a 10-bit video converter
// Behaviour
// R1 - capture whole 10-bit pixel bus on each rising clock edge only
// R2 - bit zero is code LSB, bit nine is code MSB
// R3 - driving side ties unused pixel inputs high or low
// R4 - power_off_n low: everything off including reference, no conversion
// R5 - standby_n low: low-power standby instead of conversion
// R6 - standby keeps reference running for quick recovery
// R7 - code resolves into 1024 levels, zero black, maximum white
// R8 - each code bit steers its weighted current to output or ground
// R9 - code reaches converter one cycle after capture, held until next capture
`timescale 1ns/100ps
module video_dac_input_port (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic [9:0] pixel_data_in,
	input  wire logic       power_off_n,
	input  wire logic       standby_n,
	output logic      [9:0] dac_code,
	output logic      [9:0] bit_to_output,
	output logic      [9:0] bit_to_ground,
	output logic            reference_on,
	output logic            converter_active,
	output logic      [1:0] power_state
);
	video_dac_pkg::power_state_t state;
	video_dac_pkg::power_state_t next_state;
	logic [9:0] capture;
	logic [5:0] wake_count;
	logic [5:0] next_wake_count;
	wire        want_run;
	wire        wake_done;
	wire        run_next;
	wire        ref_next;
	wire  [9:0] next_code;
	wire  [9:0] next_steer;
	wire  [9:0] next_sink;

	// true for the one state that converts live data
	function automatic logic is_live(video_dac_pkg::power_state_t s);
		return (s == video_dac_pkg::ST_RUN);
	endfunction

	// true for every state that keeps the reference alive
	function automatic logic keeps_ref(video_dac_pkg::power_state_t s);
		return (s != video_dac_pkg::ST_OFF);
	endfunction

	// wake delay loaded when leaving a low-power state
	function automatic logic [5:0] wake_load(video_dac_pkg::power_state_t s);
		logic [5:0] cycles;
		case (s)
			video_dac_pkg::ST_OFF: begin
				cycles = 6'(video_dac_pkg::POWER_OFF_UP_CYCLES); // reference restart
			end
			video_dac_pkg::ST_STANDBY: begin
				cycles = 6'(video_dac_pkg::STANDBY_UP_CYCLES); // reference still up
			end
			default: begin
				cycles = 6'h01;
			end
		endcase
		return cycles;
	endfunction

	// control decode
	assign want_run = power_off_n && standby_n;
	assign wake_done = (wake_count == 6'h01);

	// next-state decode shared by every output register
	assign run_next = is_live(next_state);
	assign ref_next = keeps_ref(next_state);

	// code and steering, forced black unless running [R4] [R5]
	assign next_code = run_next ? capture : video_dac_pkg::CODE_BLACK; // [R7] [R9]
	assign next_steer = run_next ? capture : 10'h000; // one bits to output [R8]
	assign next_sink = ~next_steer; // zero bits to ground [R8]

	// input register: full bus every rising edge, bit order kept [R1] [R2]
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			capture <= video_dac_pkg::CODE_RESET;
		end else begin
			capture <= pixel_data_in; // [R1] [R2]
		end
	end

	// power state sequencing; power-off wins over standby
	always_comb begin
		next_state = state;
		next_wake_count = 6'h00;
		if (!power_off_n) begin
			next_state = video_dac_pkg::ST_OFF; // [R4]
		end else if (!want_run) begin
			next_state = video_dac_pkg::ST_STANDBY; // [R5]
		end else begin
			case (state)
				video_dac_pkg::ST_OFF: begin
					next_state = video_dac_pkg::ST_WAKE;
					next_wake_count = wake_load(state); // full restart [R4]
				end
				video_dac_pkg::ST_STANDBY: begin
					next_state = video_dac_pkg::ST_WAKE; // quick recovery [R6]
					next_wake_count = wake_load(state); // [R6]
				end
				video_dac_pkg::ST_WAKE: begin
					next_state = wake_done ? video_dac_pkg::ST_RUN : video_dac_pkg::ST_WAKE;
					next_wake_count = wake_done ? 6'h00 : 6'(wake_count - 6'h01);
				end
				video_dac_pkg::ST_RUN: begin
					next_state = video_dac_pkg::ST_RUN;
				end
				default: begin
					next_state = video_dac_pkg::ST_OFF;
				end
			endcase
		end
	end

	// power state register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state <= video_dac_pkg::ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// wake delay counter
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wake_count <= 6'h00;
		end else begin
			wake_count <= next_wake_count;
		end
	end

	// code to converter core, one cycle after capture [R9]
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dac_code <= video_dac_pkg::CODE_BLACK;
		end else begin
			dac_code <= next_code; // [R7] [R9]
		end
	end

	// per-bit steering to the output [R8]
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bit_to_output <= 10'h000;
		end else begin
			bit_to_output <= next_steer; // [R8]
		end
	end

	// per-bit steering to ground [R8]
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bit_to_ground <= 10'h3FF;
		end else begin
			bit_to_ground <= next_sink; // [R8]
		end
	end

	// reference alive in every state but off [R4] [R6]
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reference_on <= 1'b0;
		end else begin
			reference_on <= ref_next; // [R4] [R6]
		end
	end

	// conversion only while running [R4] [R5]
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			converter_active <= 1'b0;
		end else begin
			converter_active <= run_next; // [R4] [R5]
		end
	end

	// state shown for observation
	assign power_state = state;

endmodule

//--- verif/video_dac_chk.sv
// assertions on the video converter input port
`timescale 1ns/100ps
module video_dac_chk (
	input wire logic clk_sys, nrst, power_off_n, standby_n, reference_on, converter_active,
	input wire logic [9:0] pixel_data_in, dac_code, bit_to_output, bit_to_ground,
	input wire logic [1:0] power_state
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// standby left, then both controls held high
	sequence s_left; power_state == 2'h1 && power_off_n && standby_n; endsequence
	sequence s_held; (power_off_n && standby_n) [*3]; endsequence
	sequence s_boot; power_state == 2'h0 ##1 power_state == 2'h2; endsequence
	property p_cap; converter_active [*4] |-> dac_code == $past(pixel_data_in, 2); endproperty
	a_cap: assert property (p_cap) else $error("code");
	property p_out; converter_active [*2] |-> bit_to_output == dac_code; endproperty
	a_out: assert property (p_out) else $error("steer");
	property p_gnd; bit_to_ground == ~bit_to_output; endproperty
	a_gnd: assert property (p_gnd) else $error("ground");
	property p_off; !power_off_n |=> !reference_on && !converter_active; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_idle; !converter_active |-> dac_code == 10'h000 && bit_to_output == 10'h000;
	endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_sby; power_off_n && !standby_n |=> !converter_active && reference_on; endproperty
	a_sby: assert property (p_sby) else $error("standby");
	property p_up; s_left ##1 s_held |-> converter_active; endproperty
	a_up: assert property (p_up) else $error("wake");
	property p_slow; s_boot |-> !converter_active [*8]; endproperty
	a_slow: assert property (p_slow) else $error("boot");
endmodule
bind video_dac_input_port video_dac_chk video_dac_chk_i (.*);

//--- verif/pixel_src.sv
// graphics controller stand-in: buffer driving every pixel line
`timescale 1ns/100ps
module pixel_src (
	input  wire logic [9:0] word,
	output logic      [9:0] pixel_data_in
);
	assign pixel_data_in = word; // all ten lines driven, none floating
endmodule

//--- verif/tb_video_dac_input_port.sv
// self-checking bench for the video converter input port
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR %0t mismatch", $time); end end
module tb_video_dac_input_port;
	logic       clk_sys = 0, nrst = 0, power_off_n = 0, standby_n = 1;
	logic [9:0] word = 10'h057, e, pixel_data_in, dac_code, bit_to_output, bit_to_ground;
	logic       reference_on, converter_active;
	logic [1:0] power_state;
	logic [9:0] q[$];
	logic [9:0] seed = 10'h057;
	int         err_count, compares, n, run;
	always #4 clk_sys = ~clk_sys;
	video_dac_input_port video_dac_input_port_i (.*);
	pixel_src pixel_src_i (.*);
	function automatic logic [9:0] lfsr(logic [9:0] v); return {v[8:0], v[9] ^ v[6]}; endfunction
	// one word per edge, noted for the watcher
	task put(logic [9:0] w); @(posedge clk_sys); word <= w; q.push_back(w); endtask
	task cyc(int k); repeat (k) begin seed = lfsr(seed); put(seed); end endtask
	task waitrun; for (n = 0; n < 99 && converter_active !== 1'b1; n++) begin cyc(1);
		@(negedge clk_sys); end
		if (n > 98) begin err_count++; conclude; end endtask
	task conclude; $display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish; endtask
	// watcher: oldest note against the settled code
	always @(negedge clk_sys) begin
		run = converter_active ? run + 1 : 0;
		if (q.size() > 2) begin
			e = q.pop_front();
			if (run > 4) begin
				`CHK(dac_code, e)
				`CHK(bit_to_output, e)
				`CHK(bit_to_ground, ~e)
			end
		end
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		nrst <= 1;
		cyc(3);
		power_off_n <= 1;
		@(negedge clk_sys);
		`CHK(reference_on, 1'b0)
		`CHK(power_state, 2'(video_dac_pkg::ST_OFF))
		$display("test off done");
		waitrun;
		`CHK(n >= video_dac_pkg::POWER_OFF_UP_CYCLES, 1'b1)
		put(10'h3FF);
		put(10'h000);
		cyc(200);
		$display("test stream done");
		standby_n <= 0;
		cyc(3);
		standby_n <= 1;
		@(negedge clk_sys);
		`CHK(reference_on, 1'b1)
		`CHK(converter_active, 1'b0)
		waitrun;
		`CHK(n < 4, 1'b1)
		cyc(9);
		$display("test standby done");
		power_off_n <= 0;
		standby_n <= 0;
		cyc(3);
		@(negedge clk_sys);
		`CHK(reference_on, 1'b0)
		`CHK(power_state, 2'(video_dac_pkg::ST_OFF))
		$display("test power down done");
		conclude;
	end
endmodule
